// ### shared/fcs_pkg.sv
// fcs_pkg: constants shared by the flash command sequencer files.
// assumes a 50 MHz system clock and word-aligned 32-bit register offsets.
`default_nettype none

package fcs_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] FCS_OFF_CLKDIV = 8'h00;
  localparam logic [7:0] FCS_OFF_STAT = 8'h04;
  localparam logic [7:0] FCS_OFF_CIDX = 8'h08;
  localparam logic [7:0] FCS_OFF_COB = 8'h0c;
  localparam logic [7:0] FCS_OFF_ISTAT = 8'h10;
  localparam logic [7:0] FCS_OFF_IMASK = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FCS_DIV_LD = 7;
  localparam int FCS_DIV_LCK = 6;
  localparam int FCS_ST_COMMAND_COMPLETE_FLAG = 7;
  localparam int FCS_ST_ACCESS_ERROR_FLAG = 5;
  localparam int FCS_ST_PROTECTION_VIOLATION_FLAG = 4;
  localparam int FCS_ST_MG1 = 1;
  localparam int FCS_ST_MG0 = 0;
  localparam int FCS_IRQ_DONE = 0;
  localparam int FCS_IRQ_ACC = 1;
  localparam int FCS_IRQ_FAIL = 2;
  localparam int FCS_IRQ_W = 3;

  // ----------------------------------------------------------------
  // reset values and command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FCS_RST_CLKDIV = 8'h00;
  localparam logic [2:0] FCS_RST_CIDX = 3'h0;
  localparam logic [7:0] FCS_CMD_ERSVFY_BLK = 8'h02;
  localparam logic [2:0] FCS_CIDX_FIRST = 3'h0;
  localparam logic [1:0] FCS_SEL_EEPROM = 2'h0;

  // ----------------------------------------------------------------
  // timing: clock rate and flash timebase
  // ----------------------------------------------------------------
  localparam int FCS_CLK_HZ = 50000000;
  localparam int FCS_TB_HZ = 1000000;
  localparam int FCS_TB_CYC = FCS_CLK_HZ / FCS_TB_HZ;

  // sequencer states
  typedef enum logic [1:0] {
    FCS_IDLE,
    FCS_REQ,
    FCS_WAIT,
    FCS_DONE
  } fcs_state_t;

endpackage : fcs_pkg

`default_nettype wire

// ### hw/fcs_timebase.sv
// fcs_timebase: divides the system clock down to the flash timebase tick.
// assumes the divider value is stable while commands run.
`timescale 1ns/1ps
`default_nettype none

module fcs_timebase
  import fcs_pkg::*;
#(
  parameter int DIV_W = 6
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // divider control
  input wire logic en_i,
  input wire logic [DIV_W-1:0] div_i,
  // timebase
  output logic tick_o
);

  logic [DIV_W-1:0] cnt_r;
  logic tick_r;

  // ----------------------------------------------------------------
  // counter: period is div_i + 1 clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (!en_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r >= div_i) begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick_o = tick_r;

endmodule : fcs_timebase

`default_nettype wire

// ### hw/fcs_seq.sv
// fcs_seq: flash command sequencer with erase verify block and clock divider.
// assumes a flash array read port on the same clock answering with valid.
//
// Behaviour
// - erase verify block is code 0x02 at index 000, checks whole block
// - selection 00 picks eeprom, 01/10/11 pick program flash
// - clearing the complete flag launches the verify reads
// - complete flag sets again only after the whole operation ends
// - a non-blank block sets both controller status bits
// - index other than 000 at launch sets access error
// - upper status bit sets on any read error or blank failure
// - lower status bit sets on uncorrectable error or blank failure
// - command object accepts writes only while no command runs
// - divider register reads fully, bit 7 never writable
// - normal mode: lock bit sets once, then divider field frozen
// - special mode: bits 6..0 always writable, bit 7 read-only
// - loaded bit reads 0 until first divider write after reset
// - reset or a special mode write with bit 6 at 0 clears the divider lock
// - divider field divides system clock to 1 MHz timebase
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module fcs_seq
  import fcs_pkg::*;
#(
  parameter int DW = 32,
  parameter int AW = 16,
  parameter int PF_WORDS = 16384,
  parameter int EE_WORDS = 1024
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // mode pin
  input wire logic special_mode_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // flash array read port
  output logic fl_rd_o,
  output logic fl_sel_pf_o,
  output logic [AW-1:0] fl_addr_o,
  input wire logic fl_valid_i,
  input wire logic [DW-1:0] fl_rdata_i,
  input wire logic fl_sbe_i,
  input wire logic fl_dbe_i,
  // status
  output logic busy_o,
  output logic tick_1mhz_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic div_ld_r, div_lck_r, command_complete_flag_r, access_error_flag_r, mg1_r, mg0_r, special_r, sel_pf_r;
  logic [5:0] div_val_r;
  logic [2:0] cidx_r, mode_sync_r;
  logic [15:0] cob_r [8];
  logic [FCS_IRQ_W-1:0] ist_r, imask_r, ev_set;
  logic [31:0] rdata_r;
  fcs_state_t state_r;
  logic [AW-1:0] addr_r, last_addr;
  logic wr_div, wr_stat, wr_cidx, wr_cob, wr_ist, wr_imask;
  logic launch, launch_bad, launch_ok, rd_done, blank_fail, fin;

  localparam logic [AW-1:0] PF_LAST = AW'(PF_WORDS - 1);
  localparam logic [AW-1:0] EE_LAST = AW'(EE_WORDS - 1);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // write strobes per register
  assign wr_div = reg_wr_i && (reg_addr_i == FCS_OFF_CLKDIV);
  assign wr_stat = reg_wr_i && (reg_addr_i == FCS_OFF_STAT);
  assign wr_cidx = reg_wr_i && (reg_addr_i == FCS_OFF_CIDX);
  assign wr_cob = reg_wr_i && (reg_addr_i == FCS_OFF_COB);
  assign wr_ist = reg_wr_i && (reg_addr_i == FCS_OFF_ISTAT);
  assign wr_imask = reg_wr_i && (reg_addr_i == FCS_OFF_IMASK);

  // ----------------------------------------------------------------
  // special mode pin synchroniser
  // ----------------------------------------------------------------
  // three stages; the mode follows once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_sync_r <= 3'h0;
      special_r <= 1'b0;
    end else begin
      mode_sync_r <= {mode_sync_r[1:0], special_mode_i};
      if (mode_sync_r[1] == mode_sync_r[2]) begin
        special_r <= mode_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // clock divider register
  // ----------------------------------------------------------------
  // loaded bit sticky
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_ld_r <= FCS_RST_CLKDIV[FCS_DIV_LD];
    end else if (wr_div) begin
      div_ld_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_lck_r <= FCS_RST_CLKDIV[FCS_DIV_LCK];
    end else if (wr_div) begin
      if (special_r) begin
        div_lck_r <= reg_wdata_i[FCS_DIV_LCK];
      end else begin
        div_lck_r <= div_lck_r | reg_wdata_i[FCS_DIV_LCK];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_val_r <= FCS_RST_CLKDIV[5:0];
    end else if (wr_div && (special_r || !div_lck_r)) begin
      div_val_r <= reg_wdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------
  // flash timebase
  // ----------------------------------------------------------------
  // divide to 1 MHz
  fcs_timebase #(
    .DIV_W(6)
  ) u_tb (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .en_i(div_ld_r),
    .div_i(div_val_r),
    .tick_o(tick_1mhz_o)
  );

  // ----------------------------------------------------------------
  // command object
  // ----------------------------------------------------------------
  // writes only while idle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cidx_r <= FCS_RST_CIDX;
    end else if (wr_cidx && command_complete_flag_r) begin
      cidx_r <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++) begin
        cob_r[i] <= 16'h0000;
      end
    end else if (wr_cob && command_complete_flag_r) begin
      cob_r[cidx_r] <= reg_wdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // launch decode
  // ----------------------------------------------------------------
  // launch by clearing command_complete_flag (write one)
  assign launch = wr_stat && reg_wdata_i[FCS_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_r;
  assign launch_bad = (cidx_r != FCS_CIDX_FIRST)
                      || (cob_r[0][15:8] != FCS_CMD_ERSVFY_BLK);
  assign launch_ok = launch && !launch_bad;

  // read answer outcome
  assign rd_done = (state_r == FCS_WAIT) && fl_valid_i;
  assign blank_fail = rd_done && (fl_rdata_i != {DW{1'b1}});
  assign last_addr = sel_pf_r ? PF_LAST : EE_LAST;

  // ----------------------------------------------------------------
  // verify sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= FCS_IDLE;
    end else begin
      unique case (state_r)
        FCS_IDLE: begin
          if (launch) begin
            state_r <= launch_bad ? FCS_DONE : FCS_REQ;
          end
        end
        FCS_REQ: begin
          state_r <= FCS_WAIT;
        end
        FCS_WAIT: begin
          if (fl_valid_i) begin
            state_r <= (addr_r == last_addr) ? FCS_DONE : FCS_REQ;
          end
        end
        FCS_DONE: begin
          state_r <= FCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_pf_r <= 1'b0;
    end else if (launch_ok) begin
      sel_pf_r <= (cob_r[0][1:0] != FCS_SEL_EEPROM);
    end
  end

  // walk every word of the block
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_r <= '0;
    end else if (launch_ok) begin
      addr_r <= '0;
    end else if (rd_done && (addr_r != last_addr)) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  assign fl_rd_o = (state_r == FCS_REQ);
  assign fl_addr_o = addr_r;
  assign fl_sel_pf_o = sel_pf_r;
  assign busy_o = !command_complete_flag_r;
  assign fin = (state_r == FCS_DONE);

  // ----------------------------------------------------------------
  // flash status register
  // ----------------------------------------------------------------
  // command_complete_flag set only at the end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      command_complete_flag_r <= 1'b1;
    end else if (launch) begin
      command_complete_flag_r <= 1'b0;
    end else if (fin) begin
      command_complete_flag_r <= 1'b1;
    end
  end

  // access error at launch, write one clears
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      access_error_flag_r <= 1'b0;
    end else if (launch && launch_bad) begin
      access_error_flag_r <= 1'b1;
    end else if (wr_stat && reg_wdata_i[FCS_ST_ACCESS_ERROR_FLAG]) begin
      access_error_flag_r <= 1'b0;
    end
  end

  // upper bit: any error or blank fail
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mg1_r <= 1'b0;
    end else if (launch_ok) begin
      mg1_r <= 1'b0;
    end else if (rd_done && (fl_sbe_i || fl_dbe_i || blank_fail)) begin
      mg1_r <= 1'b1;
    end
  end

  // lower bit: uncorrectable or blank fail
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mg0_r <= 1'b0;
    end else if (launch_ok) begin
      mg0_r <= 1'b0;
    end else if (rd_done && (fl_dbe_i || blank_fail)) begin
      mg0_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // event sources, msb first: verify failure, access error, done
  assign ev_set = {fin && mg1_r, launch && launch_bad, fin};

  // sticky bits; a set in the clearing cycle wins
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ist_r <= '0;
    end else begin
      ist_r <= (ist_r & ~(wr_ist ? reg_wdata_i[FCS_IRQ_W-1:0] : '0)) | ev_set;
    end
  end

  // mask register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      imask_r <= '0;
    end else if (wr_imask) begin
      imask_r <= reg_wdata_i[FCS_IRQ_W-1:0];
    end
  end

  assign irq_o = |(ist_r & imask_r);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // all divider bits read back
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_r <= 32'h0000_0000;
      unique case (reg_addr_i)
        FCS_OFF_CLKDIV: begin
          rdata_r[7:0] <= {div_ld_r, div_lck_r, div_val_r};
        end
        FCS_OFF_STAT: begin
          rdata_r[FCS_ST_COMMAND_COMPLETE_FLAG] <= command_complete_flag_r;
          rdata_r[FCS_ST_ACCESS_ERROR_FLAG] <= access_error_flag_r; // protection flag never set, reads 0
          rdata_r[FCS_ST_MG1] <= mg1_r;
          rdata_r[FCS_ST_MG0] <= mg0_r;
        end
        FCS_OFF_CIDX: begin
          rdata_r[2:0] <= cidx_r;
        end
        FCS_OFF_COB: begin
          rdata_r[15:0] <= cob_r[cidx_r];
        end
        FCS_OFF_ISTAT: begin
          rdata_r[FCS_IRQ_W-1:0] <= ist_r;
        end
        FCS_OFF_IMASK: begin
          rdata_r[FCS_IRQ_W-1:0] <= imask_r;
        end
        default: begin
          rdata_r <= 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : fcs_seq

`default_nettype wire

// ### test/fcs_seq_properties.sv
// fcs_seq_properties: port-level checks on the flash command sequencer.
// assumes the register map and field positions of fcs_pkg.
`timescale 1ns/1ps
`default_nettype none

module fcs_seq_properties
  import fcs_pkg::*;
#(
  parameter int DW = 32,
  parameter int AW = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // mode and register port
  input wire logic special_mode_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // flash read port
  input wire logic fl_rd_o,
  input wire logic fl_sel_pf_o,
  input wire logic [AW-1:0] fl_addr_o,
  input wire logic fl_valid_i,
  input wire logic [DW-1:0] fl_rdata_i,
  input wire logic fl_sbe_i,
  input wire logic fl_dbe_i,
  // status
  input wire logic busy_o,
  input wire logic tick_1mhz_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // writes accepted only while idle; launch is a one to the complete flag
  logic wr_ok;
  logic launch;
  logic good_cmd;
  logic [2:0] cidx_r;
  logic [7:0] code_r;
  logic [1:0] sel_r;
  logic ld_r;
  logic outst_r;
  assign wr_ok = reg_wr_i && !busy_o;
  assign launch = wr_ok && reg_addr_i == FCS_OFF_STAT && reg_wdata_i[FCS_ST_COMMAND_COMPLETE_FLAG];
  assign good_cmd = cidx_r == FCS_CIDX_FIRST && code_r == FCS_CMD_ERSVFY_BLK;

  // shadow of index, command code and block selection
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cidx_r <= 3'h0;
      code_r <= 8'h00;
      sel_r <= 2'h0;
    end else begin
      if (wr_ok && reg_addr_i == FCS_OFF_CIDX) cidx_r <= reg_wdata_i[2:0];
      if (wr_ok && reg_addr_i == FCS_OFF_COB && cidx_r == FCS_CIDX_FIRST) begin
        code_r <= reg_wdata_i[15:8];
        sel_r <= reg_wdata_i[1:0];
      end
    end
  end

  // divider written since reset
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) ld_r <= 1'b0;
    else if (reg_wr_i && reg_addr_i == FCS_OFF_CLKDIV) ld_r <= 1'b1;
  end

  // one flash read waiting for its answer
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) outst_r <= 1'b0;
    else if (fl_rd_o) outst_r <= 1'b1;
    else if (fl_valid_i) outst_r <= 1'b0;
  end

  a_launch_sets_busy: assert property (launch |=> busy_o)
    else $error("launch did not clear the complete flag");
  a_good_launch_reads: assert property (launch && good_cmd |=> fl_rd_o)
    else $error("verify launch issued no flash read");
  a_bad_launch_short: assert property (launch && !good_cmd |=> busy_o && !fl_rd_o ##1 !busy_o)
    else $error("refused launch did not finish in two cycles");
  a_wait_keeps_busy: assert property (outst_r |-> busy_o)
    else $error("complete flag set while a read was pending");
  a_read_addr_held: assert property (outst_r && !fl_valid_i |=> $stable(fl_addr_o) && $stable(fl_sel_pf_o))
    else $error("flash address moved before the answer");
  a_one_read_out: assert property (outst_r |-> !fl_rd_o)
    else $error("second flash read while one pending");
  a_block_select_map: assert property (fl_rd_o |-> fl_sel_pf_o == (sel_r != FCS_SEL_EEPROM))
    else $error("block select does not follow selection code");
  a_loaded_bit_read: assert property (reg_rd_i && reg_addr_i == FCS_OFF_CLKDIV |=> reg_rdata_o[FCS_DIV_LD] == ld_r)
    else $error("divider loaded bit wrong");
  a_tick_after_load: assert property (tick_1mhz_o |-> ld_r)
    else $error("timebase ticks before divider load");
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside the answer cycle");

  c_good_launch: cover property (launch && good_cmd);
  c_bad_launch: cover property (launch && !good_cmd);
  c_read_answer: cover property (outst_r && fl_valid_i && fl_dbe_i);
  c_tick: cover property (tick_1mhz_o);
endmodule : fcs_seq_properties

bind fcs_seq fcs_seq_properties #(.DW(DW), .AW(AW)) u_props (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .special_mode_i(special_mode_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_rd_o(fl_rd_o),
  .fl_sel_pf_o(fl_sel_pf_o), .fl_addr_o(fl_addr_o), .fl_valid_i(fl_valid_i),
  .fl_rdata_i(fl_rdata_i), .fl_sbe_i(fl_sbe_i), .fl_dbe_i(fl_dbe_i), .busy_o(busy_o),
  .tick_1mhz_o(tick_1mhz_o), .irq_o(irq_o)
);

`default_nettype wire

// ### test/fcs_seq_tb_top.sv
// fcs_seq_tb_top: self-checking bench for the flash command sequencer.
// assumes small block sizes and a bench-driven flash read port.
`timescale 1ns/1ps
`default_nettype none

module fcs_seq_tb_top
  import fcs_pkg::*;
;
  localparam int PFW = 4;
  localparam int EEW = 2;
  localparam logic [15:0] NONE = 16'hffff;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, special_mode_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, fl_rdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, fl_valid_i = 1'b0, fl_sbe_i = 1'b0, fl_dbe_i = 1'b0;
  logic fl_rd_o, fl_sel_pf_o, busy_o, tick_1mhz_o, irq_o;
  logic exp_pf = 1'b0;
  logic [15:0] fl_addr_o, raddr = 16'h0, bad_a = NONE, sbe_a = NONE, dbe_a = NONE;
  int lat = 0, wcnt = 0, n_rd = 0, cyc = 0, miscompares = 0, samples_checked = 0;

  fcs_seq #(.PF_WORDS(PFW), .EE_WORDS(EEW)) u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .special_mode_i(special_mode_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_rd_o(fl_rd_o),
    .fl_sel_pf_o(fl_sel_pf_o), .fl_addr_o(fl_addr_o), .fl_valid_i(fl_valid_i),
    .fl_rdata_i(fl_rdata_i), .fl_sbe_i(fl_sbe_i), .fl_dbe_i(fl_dbe_i), .busy_o(busy_o),
    .tick_1mhz_o(tick_1mhz_o), .irq_o(irq_o));

  always #10 clk_sys_i = ~clk_sys_i;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // run-time ceiling
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // array stays erased except the word at bad_a, which reads with bit 0 clear
  // flash array: answers each read lat+1 cycles after sampling it, word data all ones unless marked
  always @(posedge clk_sys_i) begin
    fl_valid_i <= 1'b0;
    fl_sbe_i <= 1'b0;
    fl_dbe_i <= 1'b0;
    fl_rdata_i <= 32'h0;
    if (fl_rd_o === 1'b1) begin
      check("flash read address", 32'(n_rd), 32'(fl_addr_o));
      check("flash block select", {31'h0, exp_pf}, {31'h0, fl_sel_pf_o});
      n_rd <= n_rd + 1;
      raddr <= fl_addr_o;
      wcnt <= lat + 1;
    end else if (wcnt > 0) begin
      wcnt <= wcnt - 1;
      if (wcnt == 1) begin
        fl_valid_i <= 1'b1;
        fl_rdata_i <= (raddr == bad_a) ? 32'hffff_fffe : 32'hffff_ffff;
        fl_sbe_i <= raddr == sbe_a;
        fl_dbe_i <= raddr == dbe_a;
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 check(what, exp, reg_rdata_o);
  endtask : rd

  task automatic wait_idle();
    for (int i = 0; i < 400 && busy_o !== 1'b0; i++) @(posedge clk_sys_i);
    check("busy", 32'h0, {31'h0, busy_o});
  endtask : wait_idle

  // divider register: load, tick period, lock, special mode, reset
  task automatic t_divider();
    int n;
    rd(FCS_OFF_CLKDIV, 32'h00, "divider after reset");
    rd(8'h20, 32'h0, "unmapped read");
    check("busy before divider write", 32'h0, {31'h0, busy_o});
    wr(FCS_OFF_CLKDIV, 32'h04);
    rd(FCS_OFF_CLKDIV, 32'h84, "divider loaded");
    n = 0;
    while (tick_1mhz_o !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (tick_1mhz_o !== 1'b1 && n < 100);
    check("tick period", 32'd5, 32'(n));
    wr(FCS_OFF_CLKDIV, 32'h43);
    rd(FCS_OFF_CLKDIV, 32'hc3, "divider locked");
    wr(FCS_OFF_CLKDIV, 32'h05);
    rd(FCS_OFF_CLKDIV, 32'hc3, "divider frozen");
    wr(FCS_OFF_CLKDIV, 32'h80);
    rd(FCS_OFF_CLKDIV, 32'hc3, "lock kept");
    special_mode_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    wr(FCS_OFF_CLKDIV, 32'h05);
    rd(FCS_OFF_CLKDIV, 32'h85, "special write");
    wr(FCS_OFF_CLKDIV, 32'h00);
    rd(FCS_OFF_CLKDIV, 32'h80, "bit 7 read-only");
    special_mode_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    wr(FCS_OFF_CLKDIV, 32'h44);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(FCS_OFF_CLKDIV, 32'h00, "lock cleared by reset");
  endtask : t_divider

  // one erase verify block run with chosen block, latency and faults
  task automatic t_verify(input logic [1:0] sel, input int l, input logic [15:0] b,
                          input logic [15:0] s, input logic [15:0] d, input logic [1:0] mg);
    lat = l;
    bad_a = b;
    sbe_a = s;
    dbe_a = d;
    n_rd = 0;
    exp_pf = (sel != FCS_SEL_EEPROM);
    wr(FCS_OFF_CIDX, 32'h0);
    wr(FCS_OFF_COB, {16'h0, FCS_CMD_ERSVFY_BLK, 6'h0, sel});
    wr(FCS_OFF_STAT, 32'h80);
    #1 check("busy after launch", 32'h1, {31'h0, busy_o});
    if (l > 10) begin
      rd(FCS_OFF_STAT, 32'h00, "status while running");
      wr(FCS_OFF_CIDX, 32'h5);
    end
    wait_idle();
    check("words read", (sel == 2'h0) ? 32'(EEW) : 32'(PFW), 32'(n_rd));
    rd(FCS_OFF_STAT, {24'h0, 8'h80 | {6'h0, mg}}, "status after verify");
    rd(FCS_OFF_CIDX, 32'h0, "index after run");
  endtask : t_verify

  // launch with a bad index: access error, no reads, status bits kept
  task automatic t_bad_launch();
    n_rd = 0;
    wr(FCS_OFF_ISTAT, 32'h7);
    wr(FCS_OFF_CIDX, 32'h1);
    wr(FCS_OFF_STAT, 32'h80);
    wait_idle();
    check("reads on refused launch", 32'h0, 32'(n_rd));
    rd(FCS_OFF_STAT, 32'ha3, "status access error");
    rd(FCS_OFF_ISTAT, 32'h7, "interrupt status refused");
    wr(FCS_OFF_STAT, 32'h20);
    rd(FCS_OFF_STAT, 32'h83, "access error cleared");
  endtask : t_bad_launch

  // interrupt: masked event, unmask, clear
  task automatic t_irq();
    wr(FCS_OFF_ISTAT, 32'h7);
    wr(FCS_OFF_IMASK, 32'h0);
    t_verify(2'h1, 1, NONE, NONE, NONE, 2'h0);
    check("irq masked", 32'h0, {31'h0, irq_o});
    rd(FCS_OFF_ISTAT, 32'h1, "interrupt status");
    wr(FCS_OFF_IMASK, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    #1 check("irq raised", 32'h1, {31'h0, irq_o});
    wr(FCS_OFF_ISTAT, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    #1 check("irq cleared", 32'h0, {31'h0, irq_o});
  endtask : t_irq

  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_divider();
    t_verify(2'h0, 0, NONE, NONE, NONE, 2'h0);
    t_verify(2'h1, 3, NONE, NONE, NONE, 2'h0);
    t_verify(2'h2, 1, NONE, NONE, NONE, 2'h0);
    t_verify(2'h3, 15, NONE, NONE, NONE, 2'h0);
    t_verify(2'h1, 2, 16'h3, NONE, NONE, 2'h3);
    t_verify(2'h0, 1, NONE, 16'h1, NONE, 2'h2);
    t_verify(2'h2, 0, NONE, NONE, 16'h0, 2'h3);
    t_bad_launch();
    t_irq();
    summarize();
  end
endmodule : fcs_seq_tb_top

`default_nettype wire
